// *** src/plc_timer_pkg.sv ***
package plc_timer_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CTRL_OFS = 8'h00;    // Enable and behaviour select.
  localparam logic [7:0] PRESET_OFS = 8'h04;  // Sixteen-bit preset.
  localparam logic [7:0] TICKDIV_OFS = 8'h08; // Clock cycles per time-base tick.
  localparam logic [7:0] STATUS_OFS = 8'h0c;  // Coil and busy flags, read only.
  localparam logic [7:0] VALUE_OFS = 8'h10;   // Timing value, read only.

  // Field positions.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int STAT_COIL_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Saturation ceiling of the timing value.
  localparam logic [15:0] VALUE_MAX = 16'h7fff;

  // Values after reset.
  localparam logic [15:0] PRESET_RST = 16'h0000;
  localparam logic [15:0] VALUE_RST = 16'h0000;

  // Time base: one tick per millisecond at the 50 MHz system clock.
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // The four timer behaviours.
  typedef enum logic [1:0] {
    on_delay_behaviour = 2'h0,
    retentive_on_delay_behaviour = 2'h1,
    off_delay_behaviour = 2'h2,
    fixed_pulse_behaviour = 2'h3
  } mode_e;

  // Control word written by the program.
  typedef struct packed {
    mode_e mode;
    logic enable;
  } ctrl_s;

  // Timer state seen by software.
  typedef struct packed {
    logic busy;
    logic coil;
    logic [15:0] value;
  } timer_stat_s;

endpackage

// *** src/plc_tick_gen.sv ***
`timescale 1ns/10ps
`default_nettype none

// Divides the system clock down to a one-cycle time-base tick.
module plc_tick_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] div_i,
  output logic tick_o
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // A divider of zero or one still yields a tick every cycle, never a stall.
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 32'h0000_0001;
    if (cnt_next >= div_i) begin
      cnt_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end

  // Counter registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule // plc_tick_gen

`default_nettype wire

// *** src/plc_edge_det.sv ***
`timescale 1ns/10ps
`default_nettype none

// Detects rising and falling edges of a level from the same clock domain.
module plc_edge_det (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_reg;

  // Reset low, so an enable already high after reset counts as a rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule // plc_edge_det

`default_nettype wire

// *** src/plc_instruction_timer_unit.sv ***
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: On-delay counts while enabled, saturates at 32767.
// R2: On-delay modes: coil on when value reaches preset.
// R3: On-delay disabled: clear value, coil off.
// R4: On-delay first evaluation clears value and coil.
// R5: Retentive counts while enabled, saturates at 32767.
// R6: Retentive disabled: value and coil hold.
// R7: Off-delay starts timing on enable falling edge.
// R8: Off-delay counts to preset, coil off, freezes.
// R9: Off-delay never starts from a plain low.
// R10: Off-delay enabled: clear value, coil on.
// R11: Pulse starts on rising edge when idle.
// R12: Pulse ignores enable while timing, coil on.
// R13: Pulse ends at preset: clear value, coil off.
// R14: Value advances by one per time-base tick.
// R15: Program holds mode and preset while active.
module plc_instruction_timer_unit
  import plc_timer_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Timer coil.
  output logic COIL_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  ctrl_s ctrl_reg;              // Enable and behaviour, written by software.
  ctrl_s ctrl_next;             // Next control word.
  logic [15:0] preset_reg;      // Preset value.
  logic [15:0] preset_next;     // Next preset.
  logic [31:0] tickdiv_reg;     // Clock cycles per tick.
  logic [31:0] tickdiv_next;    // Next tick divider.
  logic [31:0] prdata_reg;      // Read data held for the bus.
  logic [31:0] prdata_next;     // Next read data.
  logic pready_reg;             // Ready, raised one cycle into the access phase.
  logic pready_next;            // Next ready.
  logic pslverr_reg;            // Error answer for unmapped addresses.
  logic pslverr_next;           // Next error answer.
  logic acc_done;               // The access completes on this edge.
  logic hit;                    // Address maps to a register.
  timer_stat_s stat;            // Timer state gathered for reads.

  // Completion edge: the master sees pready high with psel and penable.
  assign acc_done = PSEL_I & PENABLE_I & pready_reg;

  // Decode, read mux and write effects; one wait state keeps outputs registered.
  always_comb begin
    ctrl_next = ctrl_reg;
    preset_next = preset_reg;
    tickdiv_next = tickdiv_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = 1'b0;
    hit = 1'b1;
    case (PADDR_I)
      CTRL_OFS: prdata_next = {29'h0, ctrl_reg};
      PRESET_OFS: prdata_next = {16'h0, preset_reg};
      TICKDIV_OFS: prdata_next = tickdiv_reg;
      STATUS_OFS: prdata_next = {30'h0, stat.busy, stat.coil};
      VALUE_OFS: prdata_next = {16'h0, stat.value};
      default: begin
        // Unmapped addresses read zero and answer with an error.
        prdata_next = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    if (PSEL_I & PENABLE_I & ~pready_reg) begin
      // First access cycle: prepare the answer for the next edge.
      pready_next = 1'b1;
      pslverr_next = ~hit;
    end else begin
      prdata_next = prdata_reg;
    end
    if (acc_done & PWRITE_I) begin
      // Writes take effect only at the completing edge.
      case (PADDR_I)
        CTRL_OFS: ctrl_next = ctrl_s'(PWDATA_I[2:0]);
        PRESET_OFS: preset_next = PWDATA_I[15:0];
        TICKDIV_OFS: tickdiv_next = PWDATA_I;
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // Register file flops.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg <= '{mode: on_delay_behaviour, enable: 1'b0};
      preset_reg <= PRESET_RST;
      tickdiv_reg <= 32'(TICK_CYCLES);
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      preset_reg <= preset_next;
      tickdiv_reg <= tickdiv_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Time base and enable edges

  logic tick;     // One-cycle time-base pulse.
  logic en_rise;  // Enable went from off to on.
  logic en_fall;  // Enable went from on to off.

  // Tick generator; the divider is software programmable.
  plc_tick_gen u_tick (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .div_i(tickdiv_reg),
    .tick_o(tick)
  );

  // Edge detector on the enable bit.
  plc_edge_det u_edge (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .level_i(ctrl_reg.enable),
    .rise_o(en_rise),
    .fall_o(en_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Timer core

  typedef enum logic {ST_IDLE, ST_RUN} run_e;

  run_e run_reg;          // Off-delay and pulse timing phase.
  run_e run_next;         // Next phase.
  logic [15:0] value_reg; // Timing value.
  logic [15:0] value_next;
  logic coil_reg;         // Coil output.
  logic coil_next;
  logic first_reg;        // High until the first evaluation after reset.
  logic [15:0] inc;       // Value plus one, for ticks.

  assign inc = value_reg + 16'h0001;

  // Mode and preset are assumed stable while timing; a change mid-run simply
  // continues from the current value under the new behaviour. [R15]
  always_comb begin
    run_next = run_reg;
    value_next = value_reg;
    coil_next = coil_reg;
    case (ctrl_reg.mode)
      on_delay_behaviour: begin
        run_next = ST_IDLE;
        if (first_reg) begin
          // First pass after start-up clears everything. [R4]
          value_next = VALUE_RST;
          coil_next = 1'b0;
        end else if (!ctrl_reg.enable) begin
          value_next = VALUE_RST; // [R3]
          coil_next = 1'b0;
        end else begin
          if (tick && value_reg < VALUE_MAX) begin
            value_next = inc; // [R1] [R14]
          end
          coil_next = (value_next >= preset_reg); // [R2]
        end
      end
      retentive_on_delay_behaviour: begin
        run_next = ST_IDLE;
        if (ctrl_reg.enable) begin
          if (tick && value_reg < VALUE_MAX) begin
            value_next = inc; // [R5] [R14]
          end
          coil_next = (value_next >= preset_reg); // [R2]
        end
        // When disabled the value and coil simply hold. [R6]
      end
      off_delay_behaviour: begin
        if (ctrl_reg.enable) begin
          run_next = ST_IDLE; // [R10]
          value_next = VALUE_RST;
          coil_next = 1'b1;
        end else begin
          case (run_reg)
            ST_IDLE: begin
              // Only a falling edge starts timing, never a plain low. [R7] [R9]
              if (en_fall) begin
                run_next = ST_RUN;
              end
            end
            ST_RUN: begin
              if (value_reg >= preset_reg) begin
                // Preset reached: coil drops and the value freezes. [R8]
                value_next = preset_reg;
                coil_next = 1'b0;
                run_next = ST_IDLE;
              end else if (tick) begin
                value_next = inc; // [R8] [R14]
              end
            end
            default: run_next = ST_IDLE;
          endcase
        end
      end
      fixed_pulse_behaviour: begin
        case (run_reg)
          ST_IDLE: begin
            if (en_rise) begin
              // Start from the current value with the coil on. [R11]
              run_next = ST_RUN;
              coil_next = 1'b1;
            end
          end
          ST_RUN: begin
            // The enable is not looked at while timing. [R12]
            coil_next = 1'b1;
            if (value_reg >= preset_reg) begin
              run_next = ST_IDLE; // [R13]
              value_next = VALUE_RST;
              coil_next = 1'b0;
            end else if (tick) begin
              value_next = inc; // [R14]
            end
          end
          default: run_next = ST_IDLE;
        endcase
      end
      default: run_next = ST_IDLE;
    endcase
  end

  // Timer flops.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      run_reg <= ST_IDLE;
      value_reg <= VALUE_RST;
      coil_reg <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      run_reg <= run_next;
      value_reg <= value_next;
      coil_reg <= coil_next;
      first_reg <= 1'b0;
    end
  end

  assign stat = '{busy: (run_reg == ST_RUN), coil: coil_reg, value: value_reg};
  assign COIL_O = coil_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  wire is_on = (ctrl_reg.mode == on_delay_behaviour);
  wire is_ret = (ctrl_reg.mode == retentive_on_delay_behaviour);
  wire is_off = (ctrl_reg.mode == off_delay_behaviour);
  wire is_pls = (ctrl_reg.mode == fixed_pulse_behaviour);

  sequence s_pulse_start;
    is_pls && run_reg == ST_IDLE && en_rise;
  endsequence

  sequence s_pulse_end;
    is_pls && run_reg == ST_RUN && value_reg >= preset_reg;
  endsequence

  a_on_saturate: assert property ( // [R1]
    is_on && ctrl_reg.enable && value_reg == VALUE_MAX && !first_reg
    |=> value_reg == VALUE_MAX)
    else $error("on-delay value left saturation");
  a_on_coil_level: assert property ( // [R2]
    is_on && ctrl_reg.enable && !first_reg ##1 $stable(ctrl_reg) && $stable(preset_reg)
    |-> coil_reg == (value_reg >= preset_reg))
    else $error("on-delay coil does not follow value");
  a_on_disable_clear: assert property ( // [R3]
    is_on && !ctrl_reg.enable |=> value_reg == 16'h0000 && !coil_reg)
    else $error("on-delay not cleared when disabled");
  a_ret_hold: assert property ( // [R6]
    is_ret && !ctrl_reg.enable |=> $stable(value_reg) && $stable(coil_reg))
    else $error("retentive value or coil changed while disabled");

  a_tick_step: assert property ( // [R14]
    !tick && !is_pls && !(is_on && !ctrl_reg.enable) && !(is_off && ctrl_reg.enable)
    |=> value_reg <= $past(value_reg) + 16'h0001 || value_reg == $past(preset_reg))
    else $error("value moved by more than one step");

  a_off_no_start: assert property ( // [R9]
    is_off && !ctrl_reg.enable && run_reg == ST_IDLE && !en_fall
    ##1 is_off |-> run_reg == ST_IDLE)
    else $error("off-delay started without a falling edge");
  a_off_enable: assert property ( // [R10]
    is_off && ctrl_reg.enable |=> coil_reg && value_reg == 16'h0000)
    else $error("off-delay not reset while enabled");
  a_off_expire: assert property ( // [R8]
    is_off && !ctrl_reg.enable && run_reg == ST_RUN && value_reg >= preset_reg
    |=> !coil_reg && value_reg == $past(preset_reg))
    else $error("off-delay did not expire at preset");
  a_pulse_start: assert property ( // [R11]
    s_pulse_start |=> coil_reg && run_reg == ST_RUN)
    else $error("pulse did not start on rising edge");
  a_pulse_end: assert property ( // [R13]
    s_pulse_end |=> !coil_reg && value_reg == 16'h0000 && run_reg == ST_IDLE)
    else $error("pulse did not end at preset");
  a_pulse_hold: assert property ( // [R12]
    is_pls && run_reg == ST_RUN && value_reg < preset_reg && $stable(ctrl_reg.mode)
    |=> coil_reg)
    else $error("pulse coil dropped while timing");
  a_apb_ready: assert property (
    PSEL_I && PENABLE_I && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb ready not a single cycle after one wait");

endmodule // plc_instruction_timer_unit

`default_nettype wire

// *** verif/plc_prog_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Behavioural control program: an APB master that the bench steers through xfer.
module plc_prog_model (
  // Clock.
  input wire logic clk_i,
  // APB request side.
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  // APB answer side.
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i
);
  // The bus sits idle until the first transfer is asked for.
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // One transfer; address, data and direction go out whole before penable.
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= wdata;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // The request stands until ready is seen high; a hang is left to the bench watchdog.
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Stale write data is scrambled so nothing leans on it.
    pwdata_o <= ~wdata;
  endtask
endmodule // plc_prog_model

`default_nettype wire

// *** verif/plc_instruction_timer_unit_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module plc_instruction_timer_unit_tb_top;
  import plc_timer_pkg::*;

  localparam int TICKS = 4; // Small reset divider keeps the run short.

  // One timer case: stimulus beside the expected status.
  typedef struct packed {
    mode_e mode;
    logic [15:0] pre;
    logic e1;
    logic [15:0] w1;
    logic e2;
    logic [15:0] w2;
    logic coil;
    logic [15:0] val; // 16'hffff means the value is still moving.
  } row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, coil;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, v1;
  logic e;
  int num_errors = 0;
  int cmp_count = 0;
  row_s rows [11] = '{
    '{on_delay_behaviour, 16'h0, 1'b0, 16'h0, 1'b0, 16'h0, 1'b0, 16'h0},
    '{on_delay_behaviour, 16'h5, 1'b1, 16'h28, 1'b1, 16'h0, 1'b1, 16'hffff},
    '{on_delay_behaviour, 16'hc8, 1'b1, 16'h14, 1'b1, 16'h0, 1'b0, 16'hffff},
    '{on_delay_behaviour, 16'h5, 1'b1, 16'h28, 1'b0, 16'h5, 1'b0, 16'h0},
    '{on_delay_behaviour, 16'h5, 1'b1, 16'h80e8, 1'b1, 16'h0, 1'b1, 16'h7fff},
    '{retentive_on_delay_behaviour, 16'h5, 1'b1, 16'h80e8, 1'b0, 16'h9, 1'b1, 16'h7fff},
    '{off_delay_behaviour, 16'ha, 1'b1, 16'ha, 1'b1, 16'h0, 1'b1, 16'h0},
    '{off_delay_behaviour, 16'ha, 1'b1, 16'ha, 1'b0, 16'h28, 1'b0, 16'ha},
    '{off_delay_behaviour, 16'ha, 1'b0, 16'ha, 1'b0, 16'h28, 1'b0, 16'h0},
    '{fixed_pulse_behaviour, 16'ha, 1'b1, 16'h28, 1'b1, 16'h0, 1'b0, 16'h0},
    '{fixed_pulse_behaviour, 16'hc8, 1'b1, 16'h5, 1'b0, 16'ha, 1'b1, 16'hffff}
  };

  // Clock of 20 ns.
  always #10 clk = ~clk;

  plc_instruction_timer_unit #(.TICK_CYCLES(TICKS)) dut (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .COIL_O(coil));

  plc_prog_model prog (
    .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks.

  // Compares one value and counts it.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Mapped write; any error answer is a mismatch.
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    prog.xfer(1'b1, a, x, d, e);
    check("write error", {31'h0, e}, 32'h0);
  endtask

  // Mapped read into d.
  task automatic rd(input logic [7:0] a);
    prog.xfer(1'b0, a, 32'h0, d, e);
    check("read error", {31'h0, e}, 32'h0);
  endtask

  // Synchronous reset held for n edges.
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Prints counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    do_reset(6);
    // Reset values and bus refusals.
    rd(CTRL_OFS);
    check("ctrl", d, 32'h0);
    rd(PRESET_OFS);
    check("preset", d, {16'h0, PRESET_RST});
    rd(TICKDIV_OFS);
    check("tickdiv", d, 32'(TICKS));
    wr(VALUE_OFS, 32'h55);
    rd(VALUE_OFS);
    check("value", d, {16'h0, VALUE_RST});
    prog.xfer(1'b0, 8'h14, 32'h0, d, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    prog.xfer(1'b1, 8'h14, 32'h1, d, e);
    check("unmapped write error", {31'h0, e}, 32'h1);
    $display("test registers done");
    // Table of timer cases, one tick per cycle.
    foreach (rows[i]) begin
      do_reset(2);
      wr(TICKDIV_OFS, 32'h1);
      wr(PRESET_OFS, {16'h0, rows[i].pre});
      wr(CTRL_OFS, {29'h0, rows[i].mode, rows[i].e1});
      repeat (rows[i].w1) @(posedge clk);
      wr(CTRL_OFS, {29'h0, rows[i].mode, rows[i].e2});
      repeat (rows[i].w2) @(posedge clk);
      rd(STATUS_OFS);
      check("status coil", {31'h0, d[STAT_COIL_BIT]}, {31'h0, rows[i].coil});
      check("coil pin", {31'h0, coil}, {31'h0, rows[i].coil});
      // A pulse is busy exactly while its coil is on.
      if (rows[i].mode == fixed_pulse_behaviour)
        check("pulse busy", {31'h0, d[STAT_BUSY_BIT]}, {31'h0, rows[i].coil});
      rd(VALUE_OFS);
      if (rows[i].val !== 16'hffff)
        check("value", d, {16'h0, rows[i].val});
      $display("test row %0d done", i);
    end
    // Retentive value holds exactly while disabled.
    do_reset(2);
    wr(TICKDIV_OFS, 32'h1);
    wr(PRESET_OFS, 32'h3e8);
    wr(CTRL_OFS, {29'h0, retentive_on_delay_behaviour, 1'b1});
    repeat (50) @(posedge clk);
    wr(CTRL_OFS, {29'h0, retentive_on_delay_behaviour, 1'b0});
    rd(VALUE_OFS);
    v1 = d;
    repeat (30) @(posedge clk);
    rd(VALUE_OFS);
    check("held value", d, v1);
    check("held nonzero", {31'h0, v1 > 32'h28}, 32'h1);
    $display("test hold done");
    // Two reads exactly 100 cycles apart at one tick per 10 cycles.
    wr(TICKDIV_OFS, 32'ha);
    wr(CTRL_OFS, {29'h0, on_delay_behaviour, 1'b1});
    repeat (20) @(posedge clk);
    rd(VALUE_OFS);
    v1 = d;
    repeat (96) @(posedge clk);
    rd(VALUE_OFS);
    check("tick advance", d - v1, 32'ha);
    $display("test tick done");
    tally_and_finish();
  end
endmodule // plc_instruction_timer_unit_tb_top

`default_nettype wire
